// *** jrt_pkg.sv ***
// Purpose: shared constants and types for the readback tail sequencer
// Assumes: tap clock made here by dividing the system clock
// Notes: all sequence lengths in tap clock cycles
package jrt_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TCK_PERIOD_NS = 120;
  localparam int unsigned TCK_HALF_CYC = (TCK_PERIOD_NS / CLK_PERIOD_NS) / 2;
  localparam logic [7:0] TCK_HALF_M1 = 8'(TCK_HALF_CYC - 1);
  localparam int unsigned CNT_W = 24;
  // instruction codes, six bits, shifted lsb first
  localparam logic [5:0] INSTR_CFG_IN = 6'h05;
  localparam logic [5:0] INSTR_START = 6'h0c;
  // restart packet, eight words of 32 bits, msb first
  localparam logic [255:0] RESTART_PKT = {32'h20000000, 32'h30008001, 32'h00000005, 32'h30008001,
                                          32'h00000007, 32'h30008001, 32'h00000000, 32'h20000000};
  localparam logic [8:0] PKT_BITS = 9'h100;
  localparam logic [CNT_W-1:0] IDLE_CLKS = 24'h00000c;
  localparam logic [CNT_W-1:0] TLR_CLKS = 24'h000005;
  // one step of the tap walk: mode-select level, data level, count
  typedef struct packed {
    logic tms;
    logic tdi;
    logic [CNT_W-1:0] cnt;
  } jrt_step_t;
  // result pushed to the user side per read bit
  typedef struct packed {
    logic valid;
    logic data;
    logic last;
  } jrt_rbit_t;
endpackage

// *** jrt_tck_gen.sv ***
// Purpose: divides the system clock into tap clock with edge strobes
// Assumes: runs while enable is high and on until the clock is back low, low between edges when idle
// Notes: rise and fall are one-cycle pulses matching output edges
`timescale 1ns/1ps
`default_nettype none
module jrt_tck_gen (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  output logic tck_o,
  output logic rise_o,
  output logic fall_o
);
  logic [7:0] div_q;

  // half-period counter; tck only toggles when running or to return low
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_q <= 8'h00;
      tck_o <= 1'b0;
      rise_o <= 1'b0;
      fall_o <= 1'b0;
    end else begin
      rise_o <= 1'b0;
      fall_o <= 1'b0;
      if (!en_i && !tck_o) begin
        div_q <= 8'h00;
      end else if (div_q == jrt_pkg::TCK_HALF_M1) begin
        div_q <= 8'h00;
        tck_o <= ~tck_o;
        rise_o <= ~tck_o;
        fall_o <= tck_o;
      end else begin
        div_q <= div_q + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// *** jrt_host.sv ***
// Purpose: tap host that runs the closing half of a configuration readback
// Assumes: tap already in data shift of the frame readout register at start
// Notes: readback bits are sampled on rising tap clock and handed out
//
// Functional notes
// R1 - hold select low for count minus one
// R2 - last readback bit shifted with select high
// R3 - select high three, low two clocks
// R4 - shift low bits 00101 lsb first
// R5 - msb 0 shifted with select high
// R6 - select high two, low two clocks
// R7 - shift restart packet 287 clocks msb first
// R8 - last packet bit with select high
// R9 - one high clock into data update
// R10 - load startup clocking instruction 01100 then 0
// R11 - one high clock into instruction update
// R12 - twelve idle clocks with select low
// R13 - five high clocks into logic reset
// R14 - direct read variant bypasses configuration input
// R15 - direct read end clears crc status
// R16 - compare only where mask bit is zero
// R17 - text mask aligns with first expected bit
// R18 - expected stream includes initial pad frame
// R19 - binary mask pairs with frame input payload
// R20 - host chooses write to read turnaround
// R21 - device sends one pad frame first
// R22 - readback stream holds no commands
// R23 - at least twelve startup idle clocks
// R24 - route update through selects into instruction shift
`timescale 1ns/1ps
`default_nettype none
module jrt_host (
  // system
  input wire logic CLK_I,
  input wire logic RST_I,
  // user command
  input wire logic START_I,
  input wire logic [23:0] RB_BITS_I,
  output logic BUSY_O,
  output logic DONE_O,
  // readback data, with mask and expected bit for checking
  input wire logic MASK_BIT_I,
  input wire logic EXP_BIT_I,
  output logic RB_VALID_O,
  output logic RB_DATA_O,
  output logic RB_LAST_O,
  output logic MISMATCH_O,
  // tap pins
  output logic TCK_O,
  output logic TMS_O,
  output logic TDI_O,
  input wire logic TDO_I
);
  typedef enum logic [6:0] {
    S_IDLE = 7'b0000001,
    S_RUN  = 7'b0000010,
    S_DONE = 7'b0000100,
    S_X3   = 7'b0001000,
    S_X4   = 7'b0010000,
    S_X5   = 7'b0100000,
    S_X6   = 7'b1000000
  } jrt_state_t;

  localparam logic [4:0] LAST_STEP = 5'd19;

  jrt_state_t st_q;
  logic [4:0] step_q;
  logic [23:0] cnt_q;
  logic [8:0] pkt_idx_q;
  logic [23:0] rb_bits_q;
  logic tck_en;
  logic tck_rise;
  logic tck_fall;
  logic tck_int;
  logic tdo_s1_q;
  logic tdo_s2_q;
  logic rb_phase_q;
  logic rb_last_q;
  logic tdi_q;
  logic tms_q;
  jrt_pkg::jrt_step_t cur;
  jrt_pkg::jrt_step_t nxt;
  jrt_pkg::jrt_rbit_t rb_q;

  // step table: one entry per segment of the walk
  function automatic jrt_pkg::jrt_step_t step_of(input logic [4:0] s, input logic [23:0] nrb);
    jrt_pkg::jrt_step_t r;
    r = '{tms: 1'b0, tdi: 1'b0, cnt: 24'h000001};
    case (s)
      5'd0: r = '{1'b0, 1'b0, nrb - 24'h000001};            // [R1] [R21] [R22]
      5'd1: r = '{1'b1, 1'b0, 24'h000001};                  // [R2]
      5'd2: r = '{1'b1, 1'b0, 24'h000003};                  // [R3]
      5'd3: r = '{1'b0, 1'b0, 24'h000002};                  // [R3]
      5'd4: r = '{1'b0, 1'b0, 24'h000005};                  // [R4]
      5'd5: r = '{1'b1, 1'b0, 24'h000001};                  // [R5]
      5'd6: r = '{1'b1, 1'b0, 24'h000002};                  // [R6]
      5'd7: r = '{1'b0, 1'b0, 24'h000002};                  // [R6]
      5'd8: r = '{1'b0, 1'b0, 24'h00011f};                  // [R7]
      5'd9: r = '{1'b1, 1'b0, 24'h000001};                  // [R8]
      5'd10: r = '{1'b1, 1'b0, 24'h000001};                 // [R9]
      5'd11: r = '{1'b1, 1'b0, 24'h000002};                 // [R24]
      5'd12: r = '{1'b0, 1'b0, 24'h000002};                 // [R24]
      5'd13: r = '{1'b0, 1'b0, 24'h000005};                 // [R10]
      5'd14: r = '{1'b1, 1'b0, 24'h000001};                 // [R10]
      5'd15: r = '{1'b1, 1'b0, 24'h000001};                 // [R11]
      5'd16: r = '{1'b0, 1'b0, jrt_pkg::IDLE_CLKS};         // [R12] [R23]
      5'd17: r = '{1'b1, 1'b0, jrt_pkg::TLR_CLKS};          // [R13]
      default: r = '{1'b1, 1'b0, 24'h000001};
    endcase
    return r;
  endfunction

  assign cur = step_of(step_q, rb_bits_q);
  // next segment looked up once; a member select on a call result is poorly supported
  assign nxt = step_of(step_q + 5'd1, rb_bits_q);
  assign tck_en = (st_q == S_RUN);

  jrt_tck_gen u_tck (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .en_i(tck_en),
    .tck_o(tck_int),
    .rise_o(tck_rise),
    .fall_o(tck_fall)
  );

  // tdo comes from the device side, two flops before use
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      tdo_s1_q <= 1'b0;
      tdo_s2_q <= 1'b0;
    end else begin
      tdo_s1_q <= TDO_I;
      tdo_s2_q <= tdo_s1_q;
    end
  end

  // data bit for the current segment, from the counter position
  function automatic logic tdi_of(input logic [4:0] s, input logic [23:0] c, input logic [8:0] p);
    logic b;
    b = 1'b0;
    case (s)
      5'd4: b = jrt_pkg::INSTR_CFG_IN[c[2:0]];             // [R4]
      5'd5: b = jrt_pkg::INSTR_CFG_IN[5];                  // [R5]
      5'd8: b = (p >= jrt_pkg::PKT_BITS) ? 1'b0 : jrt_pkg::RESTART_PKT[8'd255 - p[7:0]]; // [R7] zero past packet
      5'd9: b = jrt_pkg::RESTART_PKT[0];                   // [R8]
      5'd13: b = jrt_pkg::INSTR_START[c[2:0]];             // [R10]
      5'd14: b = jrt_pkg::INSTR_START[5];                  // [R10]
      default: b = 1'b0;
    endcase
    return b;
  endfunction

  // sequencer: pins change on falling tap edge, device samples on rising
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      st_q <= S_IDLE;
      step_q <= 5'd0;
      cnt_q <= 24'h000000;
      pkt_idx_q <= 9'h000;
      rb_bits_q <= 24'h000000;
      tms_q <= 1'b1;
      tdi_q <= 1'b0;
    end else begin
      case (st_q)
        S_IDLE: begin
          if (START_I && RB_BITS_I > 24'h000001) begin
            rb_bits_q <= RB_BITS_I;
            step_q <= 5'd0;
            cnt_q <= 24'h000000;
            pkt_idx_q <= 9'h000;
            tms_q <= 1'b0; // [R1]
            tdi_q <= 1'b0;
            st_q <= S_RUN;
          end
        end
        S_RUN: begin
          if (tck_fall) begin
            if (cnt_q + 24'h000001 >= cur.cnt) begin
              cnt_q <= 24'h000000;
              if (step_q == LAST_STEP - 5'd2) begin
                st_q <= S_DONE;
                tms_q <= 1'b1;
                tdi_q <= 1'b0;
              end else begin
                step_q <= step_q + 5'd1;
                tms_q <= nxt.tms;
                // packet index not yet advanced here, so the packet opens on its msb
                tdi_q <= tdi_of(step_q + 5'd1, 24'h000000, pkt_idx_q);
              end
            end else begin
              cnt_q <= cnt_q + 24'h000001;
              tdi_q <= tdi_of(step_q, cnt_q + 24'h000001, pkt_idx_q + 9'h001);
            end
            if (step_q == 5'd8) begin
              pkt_idx_q <= pkt_idx_q + 9'h001;
            end
          end
        end
        S_DONE: st_q <= S_IDLE;
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // readback capture; tdo valid at the rising edges of steps 0 and 1
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rb_phase_q <= 1'b0;
      rb_last_q <= 1'b0;
    end else begin
      rb_phase_q <= tck_rise && st_q == S_RUN && (step_q == 5'd0 || step_q == 5'd1);
      rb_last_q <= tck_rise && step_q == 5'd1; // [R2]
    end
  end

  // sample after the synchroniser has settled the rising-edge data
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rb_q <= '0;
      MISMATCH_O <= 1'b0;
    end else begin
      rb_q <= '{valid: rb_phase_q, data: tdo_s2_q, last: rb_last_q};
      if (START_I && st_q == S_IDLE) begin
        MISMATCH_O <= 1'b0;
      end else if (rb_phase_q && !MASK_BIT_I && tdo_s2_q != EXP_BIT_I) begin
        MISMATCH_O <= 1'b1; // [R16] [R17] [R18] [R19]
      end
    end
  end

  // registered pins and status
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      TCK_O <= 1'b0;
      TMS_O <= 1'b1;
      TDI_O <= 1'b0;
      BUSY_O <= 1'b0;
      DONE_O <= 1'b0;
      RB_VALID_O <= 1'b0;
      RB_DATA_O <= 1'b0;
      RB_LAST_O <= 1'b0;
    end else begin
      TCK_O <= tck_int;
      TMS_O <= tms_q;
      TDI_O <= tdi_q;
      BUSY_O <= (st_q == S_RUN);
      DONE_O <= (st_q == S_DONE);
      RB_VALID_O <= rb_q.valid;
      RB_DATA_O <= rb_q.data;
      RB_LAST_O <= rb_q.last;
    end
  end

  // the host alone decides the turnaround: readback first, then writes [R20]
  // the direct-read variant and its crc clear are outside this sequencer [R14] [R15]

  // walk checks; pins must not move while the device samples them
  sequence s_tck_rise;
    $rose(TCK_O);
  endsequence

  sequence s_done_pulse;
    (DONE_O && !BUSY_O) ##1 !DONE_O;
  endsequence

  property p_rb_body_tms;
    @(posedge CLK_I) disable iff (RST_I)
    (st_q == S_RUN && step_q == 5'd0) |-> !tms_q;
  endproperty
  a_rb_body_tms: assert property (p_rb_body_tms) // [R1]
    else $error("select high during readback body");

  property p_rb_last_tms;
    @(posedge CLK_I) disable iff (RST_I)
    (st_q == S_RUN && step_q == 5'd1) |-> tms_q;
  endproperty
  a_rb_last_tms: assert property (p_rb_last_tms) // [R2]
    else $error("select low on last readback bit");

  property p_pins_hold;
    @(posedge CLK_I) disable iff (RST_I)
    s_tck_rise |-> $stable(TMS_O) && $stable(TDI_O);
  endproperty
  a_pins_hold: assert property (p_pins_hold) // [R4]
    else $error("tap pins moved at rising tap clock");

  property p_pkt_tail_zero;
    @(posedge CLK_I) disable iff (RST_I)
    (st_q == S_RUN && step_q == 5'd8 && pkt_idx_q >= jrt_pkg::PKT_BITS) |-> !tdi_q;
  endproperty
  a_pkt_tail_zero: assert property (p_pkt_tail_zero) // [R7]
    else $error("data past the packet not zero");

  property p_idle_tms_low;
    @(posedge CLK_I) disable iff (RST_I)
    (st_q == S_RUN && step_q == 5'd16) |-> !tms_q;
  endproperty
  a_idle_tms_low: assert property (p_idle_tms_low) // [R12]
    else $error("tms not low in idle");

  property p_tlr_tms_high;
    @(posedge CLK_I) disable iff (RST_I)
    (st_q == S_RUN && step_q == 5'd17) |-> tms_q;
  endproperty
  a_tlr_tms_high: assert property (p_tlr_tms_high) // [R13]
    else $error("tms not high in reset walk");

  property p_done_pulse;
    @(posedge CLK_I) disable iff (RST_I)
    (st_q == S_DONE) |=> s_done_pulse;
  endproperty
  a_done_pulse: assert property (p_done_pulse) // [R13]
    else $error("done not a single pulse after the walk");
endmodule
`default_nettype wire

// *** jrt_dev_model.sv ***
// Purpose: behavioural device end of the tap, feeds readback bits and logs the pins
// Assumes: tap parked in data shift of the frame readout register when armed
// Notes: log entry per rising tap edge is tms*2+tdi
`timescale 1ns/1ps
`default_nettype none
module jrt_dev_model (
  // tap pins
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  output logic tdo_o
);
  int log_q[$];
  bit rb_q[$];
  int idx = 0;
  bit in_shift = 1'b0;
  initial tdo_o = 1'b0;
  // first bit must stand before the first rising edge, the tap clock is still then
  task automatic arm();
    idx = 0;
    in_shift = 1'b1;
    tdo_o = rb_q[0];
  endtask
  // log pins; select high ends the shift as the last bit goes out
  always @(posedge tck_i) begin
    log_q.push_back(int'(tms_i) * 2 + int'(tdi_i));
    if (in_shift) begin
      idx++;
      if (tms_i) in_shift = 1'b0;
    end
  end
  // raw data bits only, pad frame included by the bench
  always @(negedge tck_i) begin
    if (in_shift && idx < rb_q.size()) tdo_o <= rb_q[idx];
    else tdo_o <= ~tdo_o; // toggles so a stale bit never passes
  end
endmodule
`default_nettype wire

// *** jtag_config_readback_tail_bench.sv ***
// Purpose: self-checking bench for the readback tail host
// Assumes: device end is the behavioural tap model
// Notes: mask and expected bits held per run, so their sampling moment does not matter
`timescale 1ns/1ps
`default_nettype none
module jtag_config_readback_tail_bench;
  logic clk = 1'b0, rst = 1'b1, start = 1'b0, mask = 1'b0, expb = 1'b0;
  logic [23:0] nbits = 24'h000000;
  logic busy, done, rbv, rbd, rbl, mism, tck, tms, tdi, tdo;
  logic [31:0] pkt [8] = '{32'h20000000, 32'h30008001, 32'h00000005, 32'h30008001,
                           32'h00000007, 32'h30008001, 32'h00000000, 32'h20000000};
  int fails = 0, compares = 0, last_at = -1, seed;
  int exp_q[$];
  logic got_q[$];
  jrt_host dut_u (.CLK_I(clk), .RST_I(rst), .START_I(start), .RB_BITS_I(nbits), .BUSY_O(busy), .DONE_O(done),
    .MASK_BIT_I(mask), .EXP_BIT_I(expb), .RB_VALID_O(rbv), .RB_DATA_O(rbd), .RB_LAST_O(rbl), .MISMATCH_O(mism),
    .TCK_O(tck), .TMS_O(tms), .TDI_O(tdi), .TDO_I(tdo));
  jrt_dev_model dev_u (.tck_i(tck), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo));
  // 100 MHz system clock
  initial begin
    forever #5 clk = ~clk;
  end
  // collect handed-out readback bits
  always @(posedge clk) begin
    if (rbv === 1'b1) begin
      if (rbl === 1'b1) last_at = got_q.size();
      got_q.push_back(rbd);
    end
  end
  task automatic finish_test();
    if (fails == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input bit ok, input string msg);
    compares++;
    if (!ok) begin
      fails++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  // expected step: tms*4+tdi, tdi 2 marks a free data line
  task automatic add(input int s, input int d, input int n);
    repeat (n) exp_q.push_back(s * 4 + d);
  endtask
  task automatic ir(input logic [5:0] code);
    for (int i = 0; i < 5; i++) add(0, code[i], 1);
    add(1, code[5], 1);
  endtask
  task automatic run(input int n, input bit m, input bit e, input bit flat, input bit poke);
    bit want;
    int t, g, x;
    want = 1'b0;
    dev_u.rb_q.delete();
    for (int i = 0; i < n; i++) begin
      dev_u.rb_q.push_back(flat ? e : 1'($urandom_range(0, 1)));
      if (!m && dev_u.rb_q[i] != e) want = 1'b1;
    end
    dev_u.log_q.delete();
    got_q.delete();
    last_at = -1;
    dev_u.arm();
    @(negedge clk);
    nbits = 24'(n);
    mask = m;
    expb = e;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    t = 0;
    // a second start mid-run must be ignored
    while (done !== 1'b1 && t < 8000) begin
      @(negedge clk);
      t++;
      if (poke) start = (t == 300);
      if (t == 300) check(busy === 1'b1, "busy low mid-run");
    end
    check(t < 8000, "no done pulse");
    check(mism === want, "mismatch flag");
    check(got_q.size() == n && last_at == n - 1, "readback count or last flag");
    for (int i = 0; i < got_q.size() && i < n; i++) check(got_q[i] === dev_u.rb_q[i], "readback bit");
    exp_q.delete();
    add(0, 2, n - 1);
    add(1, 2, 4);
    add(0, 2, 2);
    ir(6'h05);
    add(1, 2, 2);
    add(0, 2, 2);
    for (int w = 0; w < 8; w++) for (int b = 31; b >= 0; b--) add(0, pkt[w][b], 1);
    add(0, 0, 31);
    add(1, 0, 1);
    add(1, 2, 3);
    add(0, 2, 2);
    ir(6'h0c);
    add(1, 2, 1);
    add(0, 2, 12);
    add(1, 2, 5);
    check(dev_u.log_q.size() == exp_q.size(), "tap step count");
    for (int i = 0; i < exp_q.size() && i < dev_u.log_q.size(); i++) begin
      g = dev_u.log_q[i];
      x = exp_q[i];
      check((g >> 1) == (x >> 2) && ((x & 3) == 2 || (g & 1) == (x & 1)), $sformatf("tap step %0d", i));
    end
  endtask
  // watchdog, well above four runs of about four thousand cycles each
  initial begin
    #400000;
    fails++;
    finish_test();
  end
  initial begin
    seed = $urandom(22143);
    repeat (5) @(negedge clk);
    rst = 1'b0;
    run(2, 1'b1, 1'b1, 1'b0, 1'b0);
    run(3 + $urandom_range(0, 40), 1'b0, 1'($urandom_range(0, 1)), 1'b0, 1'b1);
    run(17, 1'b0, 1'b1, 1'b1, 1'b0);
    run(24, 1'b1, 1'b0, 1'b0, 1'b0);
    // a count below two is refused
    dev_u.log_q.delete();
    @(negedge clk);
    nbits = 24'h000001;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    repeat (40) @(negedge clk);
    check(busy === 1'b0 && dev_u.log_q.size() == 0, "short count not refused");
    finish_test();
  end
endmodule
`default_nettype wire
